// ===== logic/eam_consts.svh
`ifndef EAM_CONSTS_SVH
`define EAM_CONSTS_SVH

// Register addresses
`define EAM_MEAS_ADDR    16'hE700
`define EAM_ACCM_ADDR    16'hE701
`define EAM_STS_ADDR     16'hE710
`define EAM_MASK_ADDR    16'hE711

// Register widths and reset values
`define EAM_AW           16
`define EAM_DW           16
`define EAM_MEAS_W       5
`define EAM_ACCM_W       4
`define EAM_MEAS_RST     5'h1C
`define EAM_ACCM_RST     4'h0
`define EAM_STS_RST      16'h0000
`define EAM_MASK_RST     16'h0000

// Field positions
`define EAM_REV_ACT_SEL  0
`define EAM_REV_REA_SEL  1
`define EAM_PEAK_LSB     2
`define EAM_ACT_FLD_LSB  0
`define EAM_REA_FLD_LSB  2
`define EAM_REVA_LSB     6
`define EAM_REVR_LSB     10
`define EAM_STS_VALID    16'h1DC0

`endif

// ===== logic/eam_pkg.sv
package eam_pkg;

   // Active accumulation field codes
   typedef enum logic [1:0] {
      EAM_ACT_SIGNED  = 2'h0,
      EAM_ACT_POSONLY = 2'h1,
      EAM_ACT_RSV     = 2'h2,
      EAM_ACT_ABS     = 2'h3
   } eam_act_e;

   // Reactive accumulation field codes
   typedef enum logic [1:0] {
      EAM_REA_SIGNED  = 2'h0,
      EAM_REA_RSV     = 2'h1,
      EAM_REA_BYACT   = 2'h2,
      EAM_REA_ABS     = 2'h3
   } eam_rea_e;

endpackage

// ===== logic/eam_top.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "eam_consts.svh"
module eam_top
   import eam_pkg::*;
#(
   parameter int PW = 32
) (
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   input  wire logic                   ce_in,
   input  wire logic [`EAM_AW-1:0]     addr_in,
   input  wire logic [`EAM_DW-1:0]     wr_data_in,
   input  wire logic                   wr_en_in,
   input  wire logic                   rd_en_in,
   output logic      [`EAM_DW-1:0]     rd_data_out,
   input  wire logic                   pwr_valid_in,
   input  wire logic [2:0][PW-1:0]     act_tot_in,
   input  wire logic [2:0][PW-1:0]     act_fund_in,
   input  wire logic [2:0][PW-1:0]     rea_tot_in,
   input  wire logic [2:0][PW-1:0]     rea_fund_in,
   input  wire logic [2:0][PW-1:0]     v_mag_in,
   input  wire logic [2:0][PW-1:0]     i_mag_in,
   output logic      [2:0][PW-1:0]     act_tot_reg_out,
   output logic      [2:0][PW-1:0]     act_fund_reg_out,
   output logic      [2:0][PW-1:0]     act_tot_cf_out,
   output logic      [2:0][PW-1:0]     act_fund_cf_out,
   output logic      [2:0][PW-1:0]     rea_tot_out,
   output logic      [2:0][PW-1:0]     rea_fund_out,
   output logic                        acc_valid_out,
   output logic      [PW-1:0]          peak_v_out,
   output logic      [PW-1:0]          peak_i_out,
   output logic      [2:0]             peak_include_out,
   output logic                        irq_out
);

   logic [`EAM_MEAS_W-1:0]  meas_q;
   logic [`EAM_ACCM_W-1:0]  accm_q;
   logic [`EAM_DW-1:0]      sts_q;
   logic [`EAM_DW-1:0]      mask_q;
   logic [`EAM_DW-1:0]      sts_set;
   logic [`EAM_DW-1:0]      sts_clr;
   logic [`EAM_DW-1:0]      rd_mux;
   logic [`EAM_DW-1:0]      rd_data_q;
   logic [2:0]              act_ev;
   logic [2:0]              rea_ev;
   logic [PW-1:0]           peak_v_d;
   logic [PW-1:0]           peak_i_d;
   logic [PW-1:0]           peak_v_q;
   logic [PW-1:0]           peak_i_q;
   logic                    acc_valid_q;
   logic                    smp;
   logic                    rev_act_sel;
   logic                    rev_rea_sel;
   logic [2:0]              peak_incl;
   eam_act_e                act_mode;
   eam_rea_e                rea_mode;

   // Field decode
   assign smp         = ce_in & pwr_valid_in;
   assign rev_act_sel = meas_q[`EAM_REV_ACT_SEL];
   assign rev_rea_sel = meas_q[`EAM_REV_REA_SEL];
   assign peak_incl   = meas_q[`EAM_PEAK_LSB +: 3];
   assign act_mode    = eam_act_e'(accm_q[`EAM_ACT_FLD_LSB +: 2]);
   assign rea_mode    = eam_rea_e'(accm_q[`EAM_REA_FLD_LSB +: 2]);

   // Magnitude of a two's complement value
   function automatic logic [PW-1:0] f_abs(input logic [PW-1:0] v);
      return v[PW-1] ? -v : v;
   endfunction

   // Active energy register term
   function automatic logic [PW-1:0] f_act_reg(input logic [PW-1:0] v, input eam_act_e m);
      case (m)
         EAM_ACT_POSONLY: return (!v[PW-1]) ? v : '0;
         EAM_ACT_ABS:     return f_abs(v);
         default:         return v;
      endcase
   endfunction

   // Active pulse term
   function automatic logic [PW-1:0] f_act_cf(input logic [PW-1:0] v, input eam_act_e m);
      case (m)
         EAM_ACT_ABS: return f_abs(v);
         default:     return v;
      endcase
   endfunction

   // Reactive term, shared by registers and pulses
   function automatic logic [PW-1:0] f_rea(input logic [PW-1:0] q, input logic [PW-1:0] a,
                                           input eam_rea_e m);
      case (m)
         EAM_REA_BYACT: return a[PW-1] ? -q : q;
         EAM_REA_ABS:   return f_abs(q);
         default:       return q;
      endcase
   endfunction

   // Per-phase accumulation terms and reverse sign tracking
   for (genvar p = 0; p < 3; p++) begin : g_ph
      logic [PW-1:0] atr_q;
      logic [PW-1:0] afr_q;
      logic [PW-1:0] atc_q;
      logic [PW-1:0] afc_q;
      logic [PW-1:0] rt_q;
      logic [PW-1:0] rf_q;
      logic          an_q;
      logic          rn_q;
      logic          a_neg;
      logic          r_neg;

      // Selected power sign for the reverse flags
      assign a_neg = rev_act_sel ? act_fund_in[p][PW-1] : act_tot_in[p][PW-1];
      assign r_neg = rev_rea_sel ? rea_fund_in[p][PW-1] : rea_tot_in[p][PW-1];
      assign act_ev[p] = smp & (a_neg != an_q);
      assign rea_ev[p] = smp & (r_neg != rn_q);

      // Accumulation terms
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            atr_q <= '0;
            afr_q <= '0;
            atc_q <= '0;
            afc_q <= '0;
            rt_q  <= '0;
            rf_q  <= '0;
         end else if (smp) begin
            atr_q <= f_act_reg(act_tot_in[p], act_mode);
            afr_q <= f_act_reg(act_fund_in[p], act_mode);
            atc_q <= f_act_cf(act_tot_in[p], act_mode);
            afc_q <= f_act_cf(act_fund_in[p], act_mode);
            rt_q  <= f_rea(rea_tot_in[p], act_tot_in[p], rea_mode);
            rf_q  <= f_rea(rea_fund_in[p], act_fund_in[p], rea_mode);
         end
      end

      // Last seen signs
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            an_q <= 1'b0;
            rn_q <= 1'b0;
         end else if (smp) begin
            an_q <= a_neg;
            rn_q <= r_neg;
         end
      end

      assign act_tot_reg_out[p]  = atr_q;
      assign act_fund_reg_out[p] = afr_q;
      assign act_tot_cf_out[p]   = atc_q;
      assign act_fund_cf_out[p]  = afc_q;
      assign rea_tot_out[p]      = rt_q;
      assign rea_fund_out[p]     = rf_q;
   end

   // Peak over included phases
   always_comb begin
      peak_v_d = '0;
      peak_i_d = '0;
      for (int k = 0; k < 3; k++) begin
         if (peak_incl[k] && v_mag_in[k] > peak_v_d) begin
            peak_v_d = v_mag_in[k];
         end
         if (peak_incl[k] && i_mag_in[k] > peak_i_d) begin
            peak_i_d = i_mag_in[k];
         end
      end
   end

   // Peak and valid outputs
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         peak_v_q    <= '0;
         peak_i_q    <= '0;
         acc_valid_q <= 1'b0;
      end else if (ce_in) begin
         acc_valid_q <= pwr_valid_in;
         if (pwr_valid_in) begin
            peak_v_q <= peak_v_d;
            peak_i_q <= peak_i_d;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meas_q  <= `EAM_MEAS_RST;
         accm_q  <= `EAM_ACCM_RST;
         mask_q  <= `EAM_MASK_RST;
      end else if (ce_in && wr_en_in) begin
         if (addr_in == `EAM_MEAS_ADDR) begin
            meas_q <= wr_data_in[`EAM_MEAS_W-1:0];
         end
         if (addr_in == `EAM_ACCM_ADDR) begin
            accm_q <= wr_data_in[`EAM_ACCM_W-1:0];
         end
         if (addr_in == `EAM_MASK_ADDR) begin
            mask_q <= wr_data_in & `EAM_STS_VALID;
         end
      end
   end

   // Sticky status, set wins over write-one-clear
   assign sts_set = (16'(act_ev) << `EAM_REVA_LSB) | (16'(rea_ev) << `EAM_REVR_LSB);
   assign sts_clr = (wr_en_in && addr_in == `EAM_STS_ADDR) ? wr_data_in : '0;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sts_q <= `EAM_STS_RST;
      end else if (ce_in) begin
         sts_q <= ((sts_q & ~sts_clr) | sts_set) & `EAM_STS_VALID;
      end
   end

   // Read mux, reserved bits read zero
   always_comb begin
      case (addr_in)
         `EAM_MEAS_ADDR:  rd_mux = 16'(meas_q);
         `EAM_ACCM_ADDR:  rd_mux = 16'(accm_q);
         `EAM_STS_ADDR:   rd_mux = sts_q;
         `EAM_MASK_ADDR:  rd_mux = mask_q;
         default:         rd_mux = 16'h0000;
      endcase
   end

   // Read data for one cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_q <= 16'h0000;
      end else if (ce_in) begin
         rd_data_q <= rd_en_in ? rd_mux : 16'h0000;
      end
   end

   assign rd_data_out      = rd_data_q;
   assign acc_valid_out    = acc_valid_q;
   assign peak_v_out       = peak_v_q;
   assign peak_i_out       = peak_i_q;
   assign peak_include_out = peak_incl;
   assign irq_out          = |(sts_q & mask_q);

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_ACT_SIGNED: assert property (
      smp && (act_mode == EAM_ACT_SIGNED || act_mode == EAM_ACT_RSV)
      |=> act_tot_reg_out[0] == $past(act_tot_in[0]) && act_fund_cf_out[0] == $past(act_fund_in[0]))
      else $error("signed active term wrong");

   AST_ACT_POS: assert property (
      smp && act_mode == EAM_ACT_POSONLY
      |=> act_tot_cf_out[0] == $past(act_tot_in[0])
          && act_tot_reg_out[0] == ($past(act_tot_in[0][PW-1]) ? '0 : $past(act_tot_in[0])))
      else $error("positive only active term wrong");

   AST_ACT_ABS: assert property (
      smp && act_mode == EAM_ACT_ABS
      |=> act_fund_reg_out[1] == ($past(act_fund_in[1][PW-1]) ? -$past(act_fund_in[1])
                                                              : $past(act_fund_in[1]))
          && act_fund_cf_out[1] == act_fund_reg_out[1])
      else $error("absolute active term wrong");

   AST_REA_SIGNED: assert property (
      smp && (rea_mode == EAM_REA_SIGNED || rea_mode == EAM_REA_RSV)
      |=> rea_tot_out[2] == $past(rea_tot_in[2]))
      else $error("signed reactive term wrong");

   AST_REA_BYACT: assert property (
      smp && rea_mode == EAM_REA_BYACT && act_fund_in[0][PW-1]
      |=> rea_fund_out[0] == -$past(rea_fund_in[0]))
      else $error("reactive sign not reversed");

   AST_REA_ABS: assert property (
      smp && rea_mode == EAM_REA_ABS && rea_tot_in[1][PW-1]
      |=> rea_tot_out[1] == -$past(rea_tot_in[1]))
      else $error("absolute reactive term wrong");

   AST_REV_ACT: assert property (
      smp && (rev_act_sel ? act_fund_in[0][PW-1] : act_tot_in[0][PW-1]) != g_ph[0].an_q
      |=> sts_q[`EAM_REVA_LSB])
      else $error("reverse active flag missed");

   AST_REV_REA: assert property (
      smp && (rev_rea_sel ? rea_fund_in[2][PW-1] : rea_tot_in[2][PW-1]) != g_ph[2].rn_q
      |=> sts_q[`EAM_REVR_LSB + 2])
      else $error("reverse reactive flag missed");

   AST_STICKY: assert property (
      sts_q[`EAM_REVA_LSB] && !(ce_in && sts_clr[`EAM_REVA_LSB])
      |=> sts_q[`EAM_REVA_LSB])
      else $error("reverse flag dropped without clear");

   AST_PEAK_ONE: assert property (
      smp && peak_incl == 3'h1 |=> peak_v_out == $past(v_mag_in[0]))
      else $error("excluded phase in peak");

   AST_RSVD: assert property (
      ce_in && rd_en_in && addr_in == `EAM_MEAS_ADDR |=> rd_data_out[7:5] == 3'h0)
      else $error("reserved bits not zero");

   COV_ABS: cover property (smp && act_mode == EAM_ACT_ABS);
   COV_BYACT: cover property (smp && rea_mode == EAM_REA_BYACT);
   COV_FLAG: cover property (!sts_q[`EAM_REVA_LSB] ##1 sts_q[`EAM_REVA_LSB]);
   COV_IRQ: cover property (!irq_out ##1 irq_out);

endmodule

// ===== testbench/test_energy_accum_mode_config.sv
`timescale 1ns/10ps
`include "eam_consts.svh"
module test_energy_accum_mode_config
   import eam_pkg::*;
;
   localparam logic [23:0] AT = 24'h00F605;
   localparam logic [23:0] AF = 24'hFE0307;
   localparam logic [23:0] RT = 24'h0204FC;
   localparam logic [23:0] RF = 24'hF90106;
   localparam logic [23:0] P  = 24'h010101;
   localparam logic [23:0] N  = 24'hFFFFFF;
   logic              clk_in, rst_in, ce_in, wr_en_in, rd_en_in, pwr_valid_in;
   logic [15:0]       addr_in, wr_data_in, rd_data_out;
   logic [2:0][7:0]   act_tot_in, act_fund_in, rea_tot_in, rea_fund_in, v_mag_in, i_mag_in;
   logic [2:0][7:0]   atr, afr, atc, afc, rto, rfo;
   logic [7:0]        peak_v_out, peak_i_out;
   logic [2:0]        peak_include_out;
   logic              acc_valid_out, irq_out;
   logic [7:0]        ev, ei;
   int                miscompares, total_checks, cycles;

   eam_top #(.PW(8)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .pwr_valid_in(pwr_valid_in), .act_tot_in(act_tot_in),
      .act_fund_in(act_fund_in), .rea_tot_in(rea_tot_in), .rea_fund_in(rea_fund_in),
      .v_mag_in(v_mag_in), .i_mag_in(i_mag_in), .act_tot_reg_out(atr), .act_fund_reg_out(afr),
      .act_tot_cf_out(atc), .act_fund_cf_out(afc), .rea_tot_out(rto), .rea_fund_out(rfo),
      .acc_valid_out(acc_valid_out), .peak_v_out(peak_v_out), .peak_i_out(peak_i_out),
      .peak_include_out(peak_include_out), .irq_out(irq_out));

   // Free running clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // Expected active term per phase; code 01 clips negatives only on the register path
   function automatic logic [23:0] xa(input logic [23:0] v, input logic [1:0] m, input bit r);
      logic [7:0] s;
      for (int p = 0; p < 3; p++) begin
         s = v[p*8+:8];
         if (m == 2'h3 && s[7]) s = -s;
         else if (m == 2'h1 && r && s[7]) s = 8'h00;
         xa[p*8+:8] = s;
      end
   endfunction

   // Expected reactive term per phase, paired with the active sign for code 10
   function automatic logic [23:0] xr(input logic [23:0] v, input logic [23:0] a,
                                      input logic [1:0] m);
      logic [7:0] s;
      for (int p = 0; p < 3; p++) begin
         s = v[p*8+:8];
         if ((m == 2'h3 && s[7]) || (m == 2'h2 && a[p*8+7])) s = -s;
         xr[p*8+:8] = s;
      end
   endfunction

   task chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_en_in   <= 1'b1;
      @(posedge clk_in);
      wr_en_in   <= 1'b0;
      #1;
   endtask

   // Read strobe for one cycle, data taken in the following cycle only
   task rdchk(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_in);
      addr_in  <= a;
      rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1;
      chk(24'(rd_data_out), 24'(exp));
   endtask

   task smp(input logic [23:0] at, input logic [23:0] af, input logic [23:0] rt,
            input logic [23:0] rf);
      @(posedge clk_in);
      act_tot_in   <= at;
      act_fund_in  <= af;
      rea_tot_in   <= rt;
      rea_fund_in  <= rf;
      pwr_valid_in <= 1'b1;
      @(posedge clk_in);
      pwr_valid_in <= 1'b0;
      #1;
   endtask

   task conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         conclude();
      end
   end

   // Main sequence
   initial begin
      {rst_in, ce_in} = 2'b11;
      {wr_en_in, rd_en_in, pwr_valid_in} = 3'b000;
      addr_in = 16'h0000;
      wr_data_in = 16'h0000;
      {act_tot_in, act_fund_in, rea_tot_in, rea_fund_in} = '0;
      v_mag_in = 24'h105030;
      i_mag_in = 24'h090207;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      #1;
      chk(24'(peak_include_out), 24'h7);
      rdchk(`EAM_MEAS_ADDR, 16'h001C);
      rdchk(`EAM_ACCM_ADDR, 16'h0000);
      wr(`EAM_MEAS_ADDR, 16'hFFE3);
      rdchk(`EAM_MEAS_ADDR, 16'h0003);
      chk(24'(peak_include_out), 24'h0);
      rdchk(16'hE7FF, 16'h0000);
      wr(`EAM_MEAS_ADDR, 16'h001C);
      $display("register test done");
      for (int m = 0; m < 4; m++) begin
         wr(`EAM_ACCM_ADDR, 16'(m * 5));
         rdchk(`EAM_ACCM_ADDR, 16'(m * 5));
         smp(AT, AF, RT, RF);
         chk(atr, xa(AT, 2'(m), 1'b1));
         chk(afr, xa(AF, 2'(m), 1'b1));
         chk(atc, xa(AT, 2'(m), 1'b0));
         chk(afc, xa(AF, 2'(m), 1'b0));
         chk(rto, xr(RT, AT, 2'(m)));
         chk(rfo, xr(RF, AF, 2'(m)));
         chk(24'(acc_valid_out), 24'h1);
      end
      $display("accumulation test done");
      for (int k = 0; k < 8; k++) begin
         wr(`EAM_MEAS_ADDR, 16'(k * 4));
         smp(AT, AF, RT, RF);
         ev = 8'h00;
         ei = 8'h00;
         for (int p = 0; p < 3; p++) begin
            if (k[p] && v_mag_in[p] > ev) ev = v_mag_in[p];
            if (k[p] && i_mag_in[p] > ei) ei = i_mag_in[p];
         end
         chk(24'(peak_include_out), 24'(k));
         chk(24'(peak_v_out), 24'(ev));
         chk(24'(peak_i_out), 24'(ei));
      end
      $display("peak test done");
      wr(`EAM_MEAS_ADDR, 16'h001C);
      wr(`EAM_MASK_ADDR, 16'hFFFF);
      rdchk(`EAM_MASK_ADDR, 16'h1DC0);
      wr(`EAM_STS_ADDR, 16'hFFFF);
      rdchk(`EAM_STS_ADDR, 16'h0000);
      chk(24'(irq_out), 24'h0);
      smp(P, P, P, P);
      rdchk(`EAM_STS_ADDR, 16'h0480);
      chk(24'(irq_out), 24'h1);
      wr(`EAM_MEAS_ADDR, 16'h001F);
      smp(P, P, P, P);
      wr(`EAM_STS_ADDR, 16'hFFFF);
      smp(N, P, N, P);
      rdchk(`EAM_STS_ADDR, 16'h0000);
      smp(P, 24'h0101FF, P, 24'hFF0101);
      rdchk(`EAM_STS_ADDR, 16'h1040);
      wr(`EAM_MASK_ADDR, 16'h0000);
      chk(24'(irq_out), 24'h0);
      wr(`EAM_STS_ADDR, 16'h0040);
      smp(P, 24'h0101FF, P, 24'hFF0101);
      rdchk(`EAM_STS_ADDR, 16'h1000);
      wr(`EAM_MASK_ADDR, 16'h1000);
      chk(24'(irq_out), 24'h1);
      wr(`EAM_STS_ADDR, 16'h1000);
      chk(24'(irq_out), 24'h0);
      $display("status test done");
      conclude();
   end
endmodule
